/* File: hw/odc_pkg.sv */
// Package for the output divider and driver mode control block.
// Assumes a single system clock and a 3-wire serial register port.
package odc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_LOCK_PIN_TEST_SELECT = 7'h17;
	localparam logic [6:0] ADDR_FIRST_DRV_CTRL      = 7'h32;
	localparam logic [6:0] ADDR_SECOND_DRV_CTRL     = 7'h34;
	// Divider registers have no printed offset
	localparam logic [6:0] ADDR_PRESCALER           = 7'h40;
	localparam logic [6:0] ADDR_FIRST_DIV_LO        = 7'h41;
	localparam logic [6:0] ADDR_FIRST_DIV_HI        = 7'h42;
	localparam logic [6:0] ADDR_SECOND_DIV_LO       = 7'h43;
	localparam logic [6:0] ADDR_SECOND_DIV_HI       = 7'h44;
	localparam logic [6:0] ADDR_STATUS              = 7'h45;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int TSEL_LSB     = 1;
	localparam int TSEL_MSB     = 3;
	localparam int DRV_SRC_BIT  = 0;
	localparam int DRV_POL_BIT  = 1;
	localparam int DRV_CUR_BIT  = 2;
	localparam int DRV_MODE_LSB = 3;
	localparam int DRV_MODE_MSB = 5;
	localparam int DRV_PDN_BIT  = 6;
	localparam logic [7:0] RST_TSEL     = 8'h00;
	localparam logic [7:0] RST_DRV_CTRL = 8'h00;
	localparam logic [3:0] RST_PRESCALE = 4'h5;
	localparam logic [9:0] RST_OUT_DIV  = 10'h001;
	localparam logic [3:0] PRESCALE_MIN = 4'h5;
	localparam logic [3:0] PRESCALE_MAX = 4'hb;
	localparam logic [9:0] OUT_DIV_MIN  = 10'h001;

	// ----------------------------------------------------------------
	// Test port codes
	// ----------------------------------------------------------------
	localparam logic [2:0] TSEL_XTAL = 3'h4;
	localparam logic [2:0] TSEL_PUMP = 3'h5;
	localparam logic [2:0] TSEL_REF  = 3'h6;
	localparam logic [2:0] TSEL_FB   = 3'h7;

	// ----------------------------------------------------------------
	// Driver mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_CMOS_BOTH = 3'h0;
	localparam logic [2:0] MODE_CMOS_POS  = 3'h1;
	localparam logic [2:0] MODE_CMOS_NEG  = 3'h2;
	localparam logic [2:0] MODE_CMOS_OFF  = 3'h3;
	localparam logic [2:0] MODE_LVDS      = 3'h4;
	localparam logic [2:0] MODE_LVPECL    = 3'h5;

	typedef enum logic [1:0] {
		ODC_FAM_CMOS,
		ODC_FAM_LVDS,
		ODC_FAM_LVPECL,
		ODC_FAM_OFF
	} odc_family_e;

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	localparam int SER_CMD_BITS  = 8;
	localparam int SER_DATA_BITS = 8;
	localparam int SER_CNT_W     = 5;

endpackage : odc_pkg

/* File: hw/odc_top.sv */
// Output divider, lock/test pin and driver mode control.
// Assumes the VCO clock is presented as a one-cycle enable on clk_sys
// and all pins are sampled through two flip-flops.
//
// What this block does
// - Lock pin goes high on PLL lock
// - Lock pin goes low on lock loss
// - Test select top bit zero gives lock
// - Codes 100..111 route internal clocks to pin
// - Prescaler divides oscillator by five to eleven
// - Prescaler feeds two independent output dividers
// - Output dividers accept ratios 1 to 1023
// - Source bit picks strap decode or register mode
// - One control register per driver, host programmed
// - CMOS codes set which pins are active
// - 100 LVDS, 101 LVPECL, both pins active
// - Strap pins decode into both driver modes
// - Strapped CMOS negative pin copies positive pin
// - Polarity in CMOS only, current and power-down
// - Each pin has its own CMOS driver
// - Outputs static during oscillator calibration
`timescale 1ns/1ns
`default_nettype none

module odc_top
	import odc_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       vco_tick,
	input  wire logic       pll_locked,
	input  wire logic       xtal_clk,
	input  wire logic       pump_up_clk,
	input  wire logic       pfd_ref_clk,
	input  wire logic       pfd_fb_clk,
	input  wire logic       vco_cal_busy,
	input  wire logic [2:0] driver_strap_pins,
	input  wire logic       ser_sclk,
	input  wire logic       ser_cs_n,
	input  wire logic       ser_sdio_in,
	output logic            ser_sdio_out,
	output logic            ser_sdio_oe_n,
	output logic            lock_status_pin,
	output logic            first_clock_output,
	output logic            first_clock_output_n,
	output logic            first_out_oe_n,
	output logic            first_out_n_oe_n,
	output logic [1:0]      first_out_family,
	output logic            first_out_high_current,
	output logic            second_clock_output,
	output logic            second_clock_output_n,
	output logic            second_out_oe_n,
	output logic            second_out_n_oe_n,
	output logic [1:0]      second_out_family,
	output logic            second_out_high_current
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] meta_ff;
	logic [NSYNC-1:0] sync_ff;
	logic [NSYNC-1:0] pin_raw;
	assign pin_raw = {pll_locked, xtal_clk, pump_up_clk, pfd_ref_clk,
		pfd_fb_clk, vco_cal_busy, driver_strap_pins, ser_sclk, ser_cs_n};

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= pin_raw;
			sync_ff <= meta_ff;
		end
	end

	logic       s_lock, s_xtal, s_pump, s_ref, s_fb, s_cal;
	logic [2:0] s_strap;
	logic       s_sclk, s_cs_n;
	assign {s_lock, s_xtal, s_pump, s_ref, s_fb, s_cal, s_strap, s_sclk,
		s_cs_n} = sync_ff;

	logic sdi_meta_ff, sdi_ff;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sdi_meta_ff <= 1'b0;
			sdi_ff      <= 1'b0;
		end else begin
			sdi_meta_ff <= ser_sdio_in;
			sdi_ff      <= sdi_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Serial port: 8-bit command (rw, 7-bit addr), 8-bit data
	// ----------------------------------------------------------------
	logic                 sclk_d_ff;
	logic [SER_CNT_W-1:0] bit_cnt_ff;
	logic [7:0]           cmd_ff;
	logic [7:0]           wdat_ff;
	logic [7:0]           rdat_ff;
	logic                 wr_stb_ff;
	logic                 sclk_rise, sclk_fall;
	logic [7:0]           rd_mux;

	assign sclk_rise = s_sclk & ~sclk_d_ff;
	assign sclk_fall = ~s_sclk & sclk_d_ff;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sclk_d_ff  <= 1'b0;
			bit_cnt_ff <= '0;
			cmd_ff     <= 8'h00;
			wdat_ff    <= 8'h00;
			wr_stb_ff  <= 1'b0;
		end else begin
			sclk_d_ff <= s_sclk;
			wr_stb_ff <= 1'b0;
			if (s_cs_n) begin
				bit_cnt_ff <= '0;
			end else if (sclk_rise) begin
				bit_cnt_ff <= bit_cnt_ff + 1'b1;
				if (bit_cnt_ff < SER_CNT_W'(SER_CMD_BITS)) begin
					cmd_ff <= {cmd_ff[6:0], sdi_ff};
				end else if (bit_cnt_ff <
					SER_CNT_W'(SER_CMD_BITS + SER_DATA_BITS)) begin
					wdat_ff <= {wdat_ff[6:0], sdi_ff};
					if (bit_cnt_ff == SER_CNT_W'(SER_CMD_BITS
						+ SER_DATA_BITS - 1) && !cmd_ff[7]) begin
						wr_stb_ff <= 1'b1;
					end
				end
			end
		end
	end

	// Read data shifts out on falling edges after the command byte
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rdat_ff       <= 8'h00;
			ser_sdio_out  <= 1'b0;
			ser_sdio_oe_n <= 1'b1;
		end else if (s_cs_n) begin
			ser_sdio_oe_n <= 1'b1;
		end else if (sclk_fall) begin
			if (bit_cnt_ff == SER_CNT_W'(SER_CMD_BITS) && cmd_ff[7]) begin
				ser_sdio_out  <= rd_mux[7];
				rdat_ff       <= {rd_mux[6:0], 1'b0};
				ser_sdio_oe_n <= 1'b0;
			end else if (!ser_sdio_oe_n) begin
				ser_sdio_out <= rdat_ff[7];
				rdat_ff      <= {rdat_ff[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] tsel_reg_ff;
	logic [7:0] drv1_ctrl_ff;
	logic [7:0] drv2_ctrl_ff;
	logic [3:0] prescale_ff;
	logic [9:0] div1_ff;
	logic [9:0] div2_ff;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tsel_reg_ff  <= RST_TSEL;
			drv1_ctrl_ff <= RST_DRV_CTRL;
			drv2_ctrl_ff <= RST_DRV_CTRL;
			prescale_ff  <= RST_PRESCALE;
			div1_ff      <= RST_OUT_DIV;
			div2_ff      <= RST_OUT_DIV;
		end else if (wr_stb_ff) begin
			case (cmd_ff[6:0])
			ADDR_LOCK_PIN_TEST_SELECT: tsel_reg_ff <= wdat_ff;
			ADDR_FIRST_DRV_CTRL:  drv1_ctrl_ff <= wdat_ff;
			ADDR_SECOND_DRV_CTRL: drv2_ctrl_ff <= wdat_ff;
			ADDR_PRESCALER: begin
				// Out-of-range ratios are clamped, never stored
				if (wdat_ff[3:0] < PRESCALE_MIN) begin
					prescale_ff <= PRESCALE_MIN;
				end else if (wdat_ff[3:0] > PRESCALE_MAX) begin
					prescale_ff <= PRESCALE_MAX;
				end else begin
					prescale_ff <= wdat_ff[3:0];
				end
			end
			ADDR_FIRST_DIV_LO:  div1_ff[7:0] <= wdat_ff;
			ADDR_FIRST_DIV_HI:  div1_ff[9:8] <= wdat_ff[1:0];
			ADDR_SECOND_DIV_LO: div2_ff[7:0] <= wdat_ff;
			ADDR_SECOND_DIV_HI: div2_ff[9:8] <= wdat_ff[1:0];
			default: ;
			endcase
		end
	end

	always_comb begin
		case (cmd_ff[6:0])
		ADDR_LOCK_PIN_TEST_SELECT: rd_mux = tsel_reg_ff;
		ADDR_FIRST_DRV_CTRL:  rd_mux = drv1_ctrl_ff;
		ADDR_SECOND_DRV_CTRL: rd_mux = drv2_ctrl_ff;
		ADDR_PRESCALER:       rd_mux = {4'h0, prescale_ff};
		ADDR_FIRST_DIV_LO:    rd_mux = div1_ff[7:0];
		ADDR_FIRST_DIV_HI:    rd_mux = {6'h00, div1_ff[9:8]};
		ADDR_SECOND_DIV_LO:   rd_mux = div2_ff[7:0];
		ADDR_SECOND_DIV_HI:   rd_mux = {6'h00, div2_ff[9:8]};
		ADDR_STATUS:          rd_mux = {5'h00, s_cal, s_lock, 1'b0};
		default:              rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Lock / test pin
	// ----------------------------------------------------------------
	logic [2:0] tsel;
	logic       pump_half_ff, ref_half_ff, fb_half_ff;
	logic       pump_d_ff, ref_d_ff, fb_d_ff;
	assign tsel = tsel_reg_ff[TSEL_MSB:TSEL_LSB];

	// Halving keeps fast PFD clocks observable on a slow pin
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			{pump_d_ff, ref_d_ff, fb_d_ff}          <= 3'h0;
			{pump_half_ff, ref_half_ff, fb_half_ff} <= 3'h0;
		end else begin
			{pump_d_ff, ref_d_ff, fb_d_ff} <= {s_pump, s_ref, s_fb};
			if (s_pump && !pump_d_ff) pump_half_ff <= ~pump_half_ff;
			if (s_ref && !ref_d_ff)   ref_half_ff  <= ~ref_half_ff;
			if (s_fb && !fb_d_ff)     fb_half_ff   <= ~fb_half_ff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			lock_status_pin <= 1'b0;
		end else begin
			case (tsel)
			TSEL_XTAL: lock_status_pin <= s_xtal;
			TSEL_PUMP: lock_status_pin <= pump_half_ff;
			TSEL_REF:  lock_status_pin <= ref_half_ff;
			TSEL_FB:   lock_status_pin <= fb_half_ff;
			default:   lock_status_pin <= s_lock;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and output dividers
	// ----------------------------------------------------------------
	logic [3:0] pre_cnt_ff;
	logic       pre_tick_ff;
	logic [9:0] cnt1_ff, cnt2_ff;
	logic       clk1_ff, clk2_ff;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pre_cnt_ff  <= 4'h0;
			pre_tick_ff <= 1'b0;
		end else begin
			pre_tick_ff <= 1'b0;
			if (vco_tick) begin
				if (pre_cnt_ff >= prescale_ff - 4'h1) begin
					pre_cnt_ff  <= 4'h0;
					pre_tick_ff <= 1'b1;
				end else begin
					pre_cnt_ff <= pre_cnt_ff + 4'h1;
				end
			end
		end
	end

	// Each output toggles once per divider period of prescaler ticks
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt1_ff <= 10'h000;
			cnt2_ff <= 10'h000;
			clk1_ff <= 1'b0;
			clk2_ff <= 1'b0;
		end else if (pre_tick_ff) begin
			if (cnt1_ff >= div1_ff - OUT_DIV_MIN || div1_ff == 10'h000) begin
				cnt1_ff <= 10'h000;
				clk1_ff <= ~clk1_ff;
			end else begin
				cnt1_ff <= cnt1_ff + 10'h001;
			end
			if (cnt2_ff >= div2_ff - OUT_DIV_MIN || div2_ff == 10'h000) begin
				cnt2_ff <= 10'h000;
				clk2_ff <= ~clk2_ff;
			end else begin
				cnt2_ff <= cnt2_ff + 10'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Strap decode and mode selection
	// ----------------------------------------------------------------
	logic [2:0] strap_mode1, strap_mode2;
	always_comb begin
		case (s_strap)
		3'h0:    {strap_mode1, strap_mode2} = {MODE_LVPECL, MODE_LVPECL};
		3'h1:    {strap_mode1, strap_mode2} = {MODE_LVPECL, MODE_LVDS};
		3'h2:    {strap_mode1, strap_mode2} = {MODE_LVDS, MODE_LVPECL};
		3'h3:    {strap_mode1, strap_mode2} = {MODE_LVPECL, MODE_CMOS_POS};
		3'h4:    {strap_mode1, strap_mode2} = {MODE_LVDS, MODE_LVDS};
		3'h5:    {strap_mode1, strap_mode2} = {MODE_LVDS, MODE_CMOS_POS};
		3'h6:    {strap_mode1, strap_mode2} = {MODE_CMOS_POS, MODE_LVDS};
		default: {strap_mode1, strap_mode2} = {MODE_CMOS_POS,
			MODE_CMOS_POS};
		endcase
	end

	logic [2:0] mode1, mode2;
	logic       strap1, strap2;
	assign strap1 = ~drv1_ctrl_ff[DRV_SRC_BIT];
	assign strap2 = ~drv2_ctrl_ff[DRV_SRC_BIT];
	assign mode1 = strap1 ? strap_mode1 :
		drv1_ctrl_ff[DRV_MODE_MSB:DRV_MODE_LSB];
	assign mode2 = strap2 ? strap_mode2 :
		drv2_ctrl_ff[DRV_MODE_MSB:DRV_MODE_LSB];

	// ----------------------------------------------------------------
	// Output drivers
	// ----------------------------------------------------------------
	// Decodes one driver; strapped CMOS drives the negative pin in phase
	function automatic logic [6:0] drv_decode(
		input logic [2:0] mode,
		input logic [7:0] ctrl,
		input logic       strap,
		input logic       clk,
		input logic       cal
	);
		logic       oe_p_n, oe_n_n, pos, neg, lvl;
		logic [1:0] fam;
		oe_p_n = 1'b1;
		oe_n_n = 1'b1;
		fam    = ODC_FAM_OFF;
		lvl    = cal ? 1'b0 : clk;
		pos    = lvl;
		neg    = ~lvl;
		case (mode)
		MODE_CMOS_BOTH, MODE_CMOS_POS, MODE_CMOS_NEG, MODE_CMOS_OFF: begin
			fam = ODC_FAM_CMOS;
			pos = lvl ^ ctrl[DRV_POL_BIT];
			neg = strap ? pos : ~pos;
			// Strapped CMOS keeps both pins live on their own drivers
			oe_p_n = (mode == MODE_CMOS_NEG) || (mode == MODE_CMOS_OFF);
			oe_n_n = !strap && ((mode == MODE_CMOS_POS) ||
				(mode == MODE_CMOS_OFF));
		end
		MODE_LVDS: begin
			fam    = ODC_FAM_LVDS;
			oe_p_n = 1'b0;
			oe_n_n = 1'b0;
		end
		MODE_LVPECL: begin
			fam    = ODC_FAM_LVPECL;
			oe_p_n = 1'b0;
			oe_n_n = 1'b0;
		end
		default: begin
			fam = ODC_FAM_OFF;
		end
		endcase
		if (ctrl[DRV_PDN_BIT]) begin
			oe_p_n = 1'b1;
			oe_n_n = 1'b1;
		end
		drv_decode = {pos, neg, oe_p_n, oe_n_n, fam, ctrl[DRV_CUR_BIT]};
	endfunction

	// Reset parks both drivers tristated, family off, low current
	localparam logic [6:0] DRV_OUT_RST = 7'h1e;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			{first_clock_output, first_clock_output_n, first_out_oe_n,
				first_out_n_oe_n, first_out_family,
				first_out_high_current} <= DRV_OUT_RST;
			{second_clock_output, second_clock_output_n, second_out_oe_n,
				second_out_n_oe_n, second_out_family,
				second_out_high_current} <= DRV_OUT_RST;
		end else begin
			{first_clock_output, first_clock_output_n, first_out_oe_n,
				first_out_n_oe_n, first_out_family,
				first_out_high_current} <=
				drv_decode(mode1, drv1_ctrl_ff, strap1, clk1_ff, s_cal);
			{second_clock_output, second_clock_output_n, second_out_oe_n,
				second_out_n_oe_n, second_out_family,
				second_out_high_current} <=
				drv_decode(mode2, drv2_ctrl_ff, strap2, clk2_ff, s_cal);
		end
	end

endmodule : odc_top

`default_nettype wire

/* File: test/odc_properties.sv */
// Checker of the odc_top ports.
// Assumes synced pins reach the outputs about three clk_sys cycles later.
`timescale 1ns/1ns
`default_nettype none
module odc_properties (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic       pll_locked,
	input wire logic       xtal_clk,
	input wire logic       pump_up_clk,
	input wire logic       pfd_ref_clk,
	input wire logic       pfd_fb_clk,
	input wire logic       vco_cal_busy,
	input wire logic       ser_cs_n,
	input wire logic       ser_sdio_oe_n,
	input wire logic       lock_status_pin,
	input wire logic       first_clock_output,
	input wire logic       first_clock_output_n,
	input wire logic       first_out_oe_n,
	input wire logic       first_out_n_oe_n,
	input wire logic [1:0] first_out_family,
	input wire logic       second_clock_output,
	input wire logic       second_out_oe_n,
	input wire logic       second_out_n_oe_n,
	input wire logic [1:0] second_out_family
);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	logic src_any;
	assign src_any = pll_locked | xtal_clk | pump_up_clk | pfd_ref_clk | pfd_fb_clk;

	property p_reset_quiet;
		disable iff (1'b0) !rstn |=> first_out_oe_n && first_out_n_oe_n
			&& second_out_oe_n && second_out_n_oe_n && ser_sdio_oe_n
			&& first_out_family == 2'h3 && !lock_status_pin;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs not quiet in reset");
	property p_diff_first;
		first_out_family inside {2'h1, 2'h2} |-> !first_out_oe_n && !first_out_n_oe_n;
	endproperty
	a_diff_first: assert property (p_diff_first)
		else $error("first differential pin idle");
	property p_diff_second;
		second_out_family inside {2'h1, 2'h2} |-> !second_out_oe_n && !second_out_n_oe_n;
	endproperty
	a_diff_second: assert property (p_diff_second)
		else $error("second differential pin idle");
	property p_off_first;
		first_out_family == 2'h3 |-> first_out_oe_n && first_out_n_oe_n;
	endproperty
	a_off_first: assert property (p_off_first)
		else $error("first driver off but driving");
	property p_off_second;
		second_out_family == 2'h3 |-> second_out_oe_n && second_out_n_oe_n;
	endproperty
	a_off_second: assert property (p_off_second)
		else $error("second driver off but driving");
	property p_cal_static;
		(vco_cal_busy && ser_cs_n) [*5] |=> $stable(first_clock_output)
			&& $stable(second_clock_output)
			&& $stable(first_clock_output_n);
	endproperty
	a_cal_static: assert property (p_cal_static)
		else $error("clock moves during calibration");
	property p_sdio_release;
		ser_cs_n [*4] |=> ser_sdio_oe_n;
	endproperty
	a_sdio_release: assert property (p_sdio_release)
		else $error("data line driven while deselected");
	// Loose on purpose: any routed source may lift the pin
	property p_lock_cause;
		$rose(lock_status_pin) |-> $past(src_any, 3) || $past(src_any, 4);
	endproperty
	a_lock_cause: assert property (p_lock_cause)
		else $error("lock pin rose without a source");
endmodule // odc_properties
`default_nettype wire

/* File: test/odc_ser_host.sv */
// Serial host model on the 3-wire register port.
// Assumes the bench calls xfer; the data line is shared with the device.
`timescale 1ns/1ns
`default_nettype none
module odc_ser_host (
	input  wire logic clk_sys,
	input  wire logic ser_sdio_out,
	input  wire logic ser_sdio_oe_n,
	output logic      ser_sclk,
	output logic      ser_cs_n,
	output logic      ser_sdio_in
);
	// Six cycles a phase keeps clear of the three-cycle minimum
	localparam int HALF = 6;
	logic host_bit;
	// Device wins the shared line while its enable is low
	assign ser_sdio_in = ser_sdio_oe_n ? host_bit : ser_sdio_out;
	initial begin
		ser_sclk = 1'b0;
		ser_cs_n = 1'b1;
		host_bit = 1'b0;
	end
	task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge clk_sys);
		ser_cs_n = 1'b0;
		for (int k = 15; k >= 0; k--) begin
			ser_sclk = 1'b0;
			host_bit = frame[k];
			repeat (HALF) @(negedge clk_sys);
			if (k < 8) rd = {rd[6:0], ser_sdio_out};
			ser_sclk = 1'b1;
			repeat (HALF) @(negedge clk_sys);
		end
		ser_sclk = 1'b0;
		ser_cs_n = 1'b1;
		// Released line shows the inverse, never the last bit
		host_bit = ~host_bit;
		repeat (4) @(negedge clk_sys);
	endtask
endmodule // odc_ser_host
`default_nettype wire

/* File: test/odc_top_tb.sv */
// Self-checking bench of odc_top with a serial host model.
// Assumes every vco_tick is high, so one tick per clk_sys cycle.
`timescale 1ns/1ns
`default_nettype none
module odc_top_tb
	import odc_pkg::*;
;
	typedef struct packed {logic [2:0] s; logic [1:0] f1; logic [1:0] f2;} odc_row_s;
	odc_row_s rows [8] = '{'{3'h0, 2'h2, 2'h2}, '{3'h1, 2'h2, 2'h1},
		'{3'h2, 2'h1, 2'h2}, '{3'h3, 2'h2, 2'h0}, '{3'h4, 2'h1, 2'h1},
		'{3'h5, 2'h1, 2'h0}, '{3'h6, 2'h0, 2'h1}, '{3'h7, 2'h0, 2'h0}};
	localparam logic [15:0] OE_EXP  = 16'hf0e4;
	localparam logic [15:0] FAM_EXP = 16'hf900;
	logic       clk_sys      = 1'b0;
	logic       rstn         = 1'b0;
	logic       vco_tick     = 1'b1;
	logic       pll_locked   = 1'b0;
	logic       xtal_clk     = 1'b0;
	logic [2:0] tclk         = 3'h0;
	logic       vco_cal_busy = 1'b0;
	logic [2:0] strap        = 3'h0;
	logic       sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, lock_pin, v;
	logic       p1, n1, oe1, noe1, hc1, p2, n2, oe2, noe2, hc2;
	logic [1:0] fam1, fam2;
	logic [7:0] rdv;
	int         n_fail       = 0;
	int         tests_run    = 0;

	always #25 clk_sys = ~clk_sys;

	odc_top i_odc_top (.clk_sys(clk_sys), .rstn(rstn), .vco_tick(vco_tick),
		.pll_locked(pll_locked), .xtal_clk(xtal_clk), .pump_up_clk(tclk[0]),
		.pfd_ref_clk(tclk[1]), .pfd_fb_clk(tclk[2]), .vco_cal_busy(vco_cal_busy),
		.driver_strap_pins(strap), .ser_sclk(sclk), .ser_cs_n(cs_n),
		.ser_sdio_in(sdio_in), .ser_sdio_out(sdio_out), .ser_sdio_oe_n(sdio_oe_n),
		.lock_status_pin(lock_pin), .first_clock_output(p1),
		.first_clock_output_n(n1), .first_out_oe_n(oe1), .first_out_n_oe_n(noe1),
		.first_out_family(fam1), .first_out_high_current(hc1),
		.second_clock_output(p2), .second_clock_output_n(n2),
		.second_out_oe_n(oe2), .second_out_n_oe_n(noe2),
		.second_out_family(fam2), .second_out_high_current(hc2));
	odc_ser_host i_odc_ser_host (.clk_sys(clk_sys), .ser_sdio_out(sdio_out),
		.ser_sdio_oe_n(sdio_oe_n), .ser_sclk(sclk), .ser_cs_n(cs_n),
		.ser_sdio_in(sdio_in));

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_odc_ser_host.xfer({1'b0, a, d}, rdv);
		repeat (6) @(negedge clk_sys);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		i_odc_ser_host.xfer({1'b1, a, 8'h00}, rdv);
		chk(rdv, e);
	endtask
	task automatic period(input bit sel, input logic [15:0] e);
		logic pv = 1'b1;
		logic cv;
		int n = 0;
		int k = 0;
		int t = 0;
		while (k < 2 && t < 25000) begin
			@(negedge clk_sys);
			cv = sel ? p2 : p1;
			n = (cv && !pv && k == 0) ? 0 : n + 1;
			if (cv && !pv) k++;
			pv = cv;
			t++;
		end
		chk(n[15:0], e);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		repeat (80000) @(posedge clk_sys);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(ADDR_LOCK_PIN_TEST_SELECT, RST_TSEL);
		rd(ADDR_FIRST_DRV_CTRL, RST_DRV_CTRL);
		rd(7'h7f, 8'h00);
		done("reset values");
		foreach (rows[i]) begin
			strap = rows[i].s;
			repeat (6) @(negedge clk_sys);
			chk(fam1, rows[i].f1);
			chk(fam2, rows[i].f2);
			chk({oe1, noe1, oe2, noe2}, 4'h0);
			if (rows[i].f1 == 2'h0) chk(n1, p1);
			if (rows[i].f2 == 2'h0) chk(n2, p2);
		end
		done("strap decode");
		for (int m = 0; m < 8; m++) begin
			wr(ADDR_FIRST_DRV_CTRL, {2'h0, m[2:0], 3'h1});
			wr(ADDR_SECOND_DRV_CTRL, {2'h0, m[2:0], 3'h1});
			chk({oe1, noe1}, OE_EXP[2*m +: 2]);
			chk({oe2, noe2}, OE_EXP[2*m +: 2]);
			chk(fam1, FAM_EXP[2*m +: 2]);
			chk(fam2, FAM_EXP[2*m +: 2]);
		end
		wr(ADDR_FIRST_DRV_CTRL, 8'h01);
		chk(n1, {~p1});
		wr(ADDR_FIRST_DRV_CTRL, 8'h45);
		chk({oe1, noe1, hc1}, 3'h7);
		rd(ADDR_FIRST_DRV_CTRL, 8'h45);
		rd(ADDR_SECOND_DRV_CTRL, 8'h39);
		wr(ADDR_SECOND_DRV_CTRL, 8'h3c);
		chk({hc2, oe2, noe2}, 3'h4);
		wr(ADDR_FIRST_DRV_CTRL, 8'h00);
		chk(fam1, 2'h0);
		done("register modes");
		period(1'b0, 16'd10);
		wr(ADDR_SECOND_DIV_LO, 8'hff);
		wr(ADDR_SECOND_DIV_HI, 8'h03);
		period(1'b1, 16'd10230);
		period(1'b0, 16'd10);
		wr(ADDR_PRESCALER, 8'h0b);
		wr(ADDR_FIRST_DIV_LO, 8'h03);
		period(1'b0, 16'd66);
		wr(ADDR_PRESCALER, 8'h02);
		rd(ADDR_PRESCALER, 8'h05);
		done("dividers");
		vco_cal_busy = 1'b1;
		repeat (6) @(negedge clk_sys);
		v = n1;
		chk({p1, p2}, 2'h0);
		repeat (30) @(negedge clk_sys);
		chk({p1, p2, n1}, {2'h0, v});
		wr(ADDR_FIRST_DRV_CTRL, 8'h03);
		chk({p1, n1}, 2'h2);
		wr(ADDR_FIRST_DRV_CTRL, 8'h00);
		vco_cal_busy = 1'b0;
		done("calibration");
		pll_locked = 1'b1;
		repeat (5) @(negedge clk_sys);
		chk(lock_pin, 1'b1);
		rd(ADDR_STATUS, 8'h02);
		pll_locked = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(lock_pin, 1'b0);
		wr(ADDR_LOCK_PIN_TEST_SELECT, 8'h06);
		pll_locked = 1'b1;
		repeat (5) @(negedge clk_sys);
		chk(lock_pin, 1'b1);
		wr(ADDR_LOCK_PIN_TEST_SELECT, 8'h08);
		xtal_clk = 1'b1;
		repeat (5) @(negedge clk_sys);
		chk(lock_pin, 1'b1);
		xtal_clk = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(lock_pin, 1'b0);
		for (int c = 0; c < 3; c++) begin
			wr(ADDR_LOCK_PIN_TEST_SELECT, 8'(10 + 2 * c));
			v = lock_pin;
			tclk[c] = 1'b1;
			repeat (5) @(negedge clk_sys);
			tclk[c] = 1'b0;
			repeat (5) @(negedge clk_sys);
			chk(lock_pin, {~v});
		end
		done("lock pin");
		wr(ADDR_FIRST_DRV_CTRL, 8'h21);
		rstn = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk({oe1, noe1, oe2, noe2, fam1}, 6'h3f);
		rstn = 1'b1;
		repeat (3) @(negedge clk_sys);
		rd(ADDR_FIRST_DRV_CTRL, RST_DRV_CTRL);
		rd(ADDR_LOCK_PIN_TEST_SELECT, RST_TSEL);
		done("mid-run reset");
		print_verdict();
	end
endmodule // odc_top_tb

bind odc_top odc_properties i_odc_properties (.clk_sys(clk_sys), .rstn(rstn),
	.pll_locked(pll_locked), .xtal_clk(xtal_clk), .pump_up_clk(pump_up_clk),
	.pfd_ref_clk(pfd_ref_clk), .pfd_fb_clk(pfd_fb_clk),
	.vco_cal_busy(vco_cal_busy), .ser_cs_n(ser_cs_n),
	.ser_sdio_oe_n(ser_sdio_oe_n), .lock_status_pin(lock_status_pin),
	.first_clock_output(first_clock_output),
	.first_clock_output_n(first_clock_output_n),
	.first_out_oe_n(first_out_oe_n), .first_out_n_oe_n(first_out_n_oe_n),
	.first_out_family(first_out_family),
	.second_clock_output(second_clock_output),
	.second_out_oe_n(second_out_oe_n), .second_out_n_oe_n(second_out_n_oe_n),
	.second_out_family(second_out_family));
`default_nettype wire
